// *** src/stl_pkg.sv ***
// shared constants, enums and bus carriers of the sensor timing logic
// assumes a 100 MHz clock and an AXI4-Lite master with 32-bit data
package stl_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_TICK_NS = 1000000;
  localparam int BASE_TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] DIV_LOW = 7'h01;
  localparam logic [6:0] DIV_MID = 7'h0a;
  localparam logic [6:0] DIV_HIGH = 7'h64;
  localparam logic [7:0] SET_MIN = 8'h0a;
  localparam logic [7:0] SET_MAX = 8'h96;
  localparam logic [7:0] SETTLE_TICKS = 8'h14;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIME = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_IDLE_OPEN_BIT = 7;
  localparam int CTRL_RANGE_LSB = 8;
  localparam int CTRL_BRIGHT_BIT = 10;
  localparam int TIME_DELAY_LSB = 0;
  localparam int TIME_HOLD_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_07ff;
  localparam logic [31:0] TIME_MASK = 32'h0000_ffff;
  localparam logic [31:0] CTRL_RST = 32'h0000_04d7;
  localparam logic [31:0] TIME_RST = 32'h0000_0a0a;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // -----------------------------------------------------------------
  // function switch patterns, bit 0 is switch one
  // -----------------------------------------------------------------
  localparam logic [6:0] PAT_FOLLOW = 7'h57;
  localparam logic [6:0] PAT_ON_WAIT = 7'h53;
  localparam logic [6:0] PAT_OFF_WAIT = 7'h55;
  localparam logic [6:0] PAT_BOTH_WAIT = 7'h51;
  localparam logic [6:0] PAT_PULSE = 7'h54;
  localparam logic [6:0] PAT_DLY_PULSE = 7'h10;
  localparam logic [6:0] PAT_CAPPED = 7'h43;
  localparam logic [6:0] PAT_OSC = 7'h59;
  localparam logic [6:0] PAT_EDGE_LATCH = 7'h76;
  localparam logic [6:0] PAT_LEVEL_LATCH = 7'h77;
  localparam logic [6:0] PAT_DLY_LATCH = 7'h73;
  localparam logic [6:0] PAT_CAP_LATCH = 7'h63;

  typedef enum logic [3:0] {
    FN_FOLLOW, FN_ON_WAIT, FN_OFF_WAIT, FN_BOTH_WAIT, FN_PULSE, FN_DLY_PULSE,
    FN_CAPPED, FN_OSC, FN_EDGE_LATCH, FN_LEVEL_LATCH, FN_DLY_LATCH, FN_CAP_LATCH, FN_NONE
  } stl_func_e;

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_DELAY, SQ_ON, SQ_HOLD, SQ_PULSE, SQ_LOCK, SQ_LATCH
  } stl_seq_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } stl_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } stl_axi_rsp_s;

endpackage

// *** src/stl_sync.sv ***
// two-stage synchroniser for the sensor and auxiliary pins
// assumes pins asynchronous to clk; only stage two is read outside
`timescale 1ns/10ps
module stl_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] pin_raw,
  output logic [1:0] pin_sync
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] held;
  } stl_sync_s;

  stl_sync_s s_ff;
  stl_sync_s nxt_s;

  always_comb begin
    nxt_s.meta = pin_raw;
    nxt_s.held = s_ff.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign pin_sync = s_ff.held;

endmodule

// *** src/stl_tick.sv ***
// timebase: 1 ms base tick and a range tick of 1, 10 or 100 ms
// assumes range_sel from the control register on the same clock
`timescale 1ns/10ps
module stl_tick #(
  parameter int BASE_CYC = stl_pkg::BASE_TICK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] range_sel,
  output logic base_tick,
  output logic range_tick
);

  typedef struct packed {
    logic [23:0] pre;
    logic [6:0] div;
    logic base;
    logic rtick;
  } stl_tick_s;

  stl_tick_s s_ff;
  stl_tick_s nxt_s;
  logic [6:0] div_lim;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.base = 1'b0;
    nxt_s.rtick = 1'b0;
    // both range bits set falls back to the longest range
    if (range_sel[1]) begin
      div_lim = stl_pkg::DIV_HIGH;
    end else if (range_sel[0]) begin
      div_lim = stl_pkg::DIV_MID;
    end else begin
      div_lim = stl_pkg::DIV_LOW;
    end
    if (s_ff.pre >= 24'(BASE_CYC - 1)) begin
      nxt_s.pre = '0;
      nxt_s.base = 1'b1;
      if (s_ff.div >= 7'(div_lim - 7'h01)) begin
        nxt_s.div = '0;
        nxt_s.rtick = 1'b1;
      end else begin
        nxt_s.div = 7'(s_ff.div + 7'h01);
      end
    end else begin
      nxt_s.pre = 24'(s_ff.pre + 24'h000001);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign base_tick = s_ff.base;
  assign range_tick = s_ff.rtick;

endmodule

// *** src/stl_core.sv ***
// sensor timing logic: twelve output functions behind an AXI4-Lite slave
// assumes raw pins asynchronous to clk, aux_n low means asserted
//
// Summary of operation
// - follow mode copies input to output
// - follow mode: auxiliary forces output off
// - on-wait: output after continuous delay time
// - on-wait: auxiliary cancels output, clears timer
// - off-wait: on at once, off after hold
// - off-wait: auxiliary blocks start, finishes hold
// - combined wait: on-delay then off-hold
// - combined wait: auxiliary resets delay, finishes hold
// - single pulse of hold length on edge
// - single pulse: auxiliary blocks trigger only
// - delayed pulse: edge, delay, then hold pulse
// - delayed pulse: auxiliary aborts delay, not pulse
// - capped follow: off after hold time
// - capped follow: auxiliary cancels, release restarts
// - oscillate: delay then hold, repeating
// - oscillate: removal lets pulse finish
// - oscillate: auxiliary cancels, hold finishes
// - edge latch: onset latches, auxiliary clears
// - level latch: presence latches, auxiliary clears
// - delay latch: delay then latch, auxiliary clears
// - capped latch: timer cleared only by auxiliary
// - bright or shadow input sense selectable
// - three shared ranges, independent delay, hold
// - output polarity idle open or closed
// - seven-bit pattern selects one function
`timescale 1ns/10ps
module stl_core #(
  parameter int BASE_CYC = stl_pkg::BASE_TICK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sense_in,
  input wire logic aux_n,
  input wire stl_pkg::stl_axi_req_s axi_req,
  output stl_pkg::stl_axi_rsp_s axi_rsp,
  output logic out_drive
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic aw_rdy;
    logic aw_hold;
    logic [stl_pkg::ADDR_W-1:0] aw_addr;
    logic w_rdy;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] tset;
    stl_pkg::stl_seq_e seq;
    logic [7:0] cnt;
    logic act_prev;
    logic [7:0] settle;
    logic settled;
    logic out_log;
    logic out_pin;
  } stl_core_s;

  stl_core_s s_ff;
  stl_core_s nxt_s;

  logic [1:0] pins;
  logic base_tick;
  logic range_tick;
  logic light;
  logic aux;
  logic act;
  logic go;
  logic trig;
  stl_pkg::stl_func_e fn;
  logic [7:0] dly;
  logic [7:0] hld;
  logic done_d;
  logic done_h;
  logic clr;
  logic run;
  logic mode_chg;
  logic [31:0] status_w;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // settings outside the adjustable span are pulled to its ends
  function automatic logic [7:0] clamp_set(input logic [7:0] v);
    if (v < stl_pkg::SET_MIN) begin
      return stl_pkg::SET_MIN;
    end else if (v > stl_pkg::SET_MAX) begin
      return stl_pkg::SET_MAX;
    end
    return v;
  endfunction

  function automatic stl_pkg::stl_func_e func_decode(input logic [6:0] p);
    unique case (p)
      stl_pkg::PAT_FOLLOW: return stl_pkg::FN_FOLLOW;
      stl_pkg::PAT_ON_WAIT: return stl_pkg::FN_ON_WAIT;
      stl_pkg::PAT_OFF_WAIT: return stl_pkg::FN_OFF_WAIT;
      stl_pkg::PAT_BOTH_WAIT: return stl_pkg::FN_BOTH_WAIT;
      stl_pkg::PAT_PULSE: return stl_pkg::FN_PULSE;
      stl_pkg::PAT_DLY_PULSE: return stl_pkg::FN_DLY_PULSE;
      stl_pkg::PAT_CAPPED: return stl_pkg::FN_CAPPED;
      stl_pkg::PAT_OSC: return stl_pkg::FN_OSC;
      stl_pkg::PAT_EDGE_LATCH: return stl_pkg::FN_EDGE_LATCH;
      stl_pkg::PAT_LEVEL_LATCH: return stl_pkg::FN_LEVEL_LATCH;
      stl_pkg::PAT_DLY_LATCH: return stl_pkg::FN_DLY_LATCH;
      stl_pkg::PAT_CAP_LATCH: return stl_pkg::FN_CAP_LATCH;
      default: return stl_pkg::FN_NONE;
    endcase
  endfunction

  stl_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_raw({aux_n, sense_in}),
    .pin_sync(pins)
  );

  stl_tick #(
    .BASE_CYC(BASE_CYC)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .range_sel(s_ff.ctrl[stl_pkg::CTRL_RANGE_LSB +: 2]),
    .base_tick(base_tick),
    .range_tick(range_tick)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    mode_chg = 1'b0;
    clr = 1'b0;
    run = 1'b1;
    light = pins[0];
    aux = ~pins[1];
    act = s_ff.ctrl[stl_pkg::CTRL_BRIGHT_BIT] ? light : ~light;
    go = act & ~aux;
    trig = act & ~s_ff.act_prev & ~aux;
    fn = func_decode(s_ff.ctrl[stl_pkg::CTRL_FUNC_LSB +: 7]);
    dly = clamp_set(s_ff.tset[stl_pkg::TIME_DELAY_LSB +: 8]);
    hld = clamp_set(s_ff.tset[stl_pkg::TIME_HOLD_LSB +: 8]);
    done_d = s_ff.cnt >= dly;
    done_h = s_ff.cnt >= hld;
    status_w = '0;
    status_w[0] = s_ff.out_log;
    status_w[1] = act;
    status_w[2] = aux;
    status_w[3] = s_ff.settled;
    status_w[4] = fn != stl_pkg::FN_NONE;
    status_w[10:8] = s_ff.seq;
    status_w[23:16] = s_ff.cnt;

    // bus write channels taken in either order
    if (s_ff.aw_rdy && axi_req.awvalid) begin
      nxt_s.aw_hold = 1'b1;
      nxt_s.aw_addr = axi_req.awaddr;
    end
    if (s_ff.w_rdy && axi_req.wvalid) begin
      nxt_s.w_hold = 1'b1;
      nxt_s.w_data = axi_req.wdata;
      nxt_s.w_strb = axi_req.wstrb;
    end
    if (s_ff.bvalid && axi_req.bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid) begin
      nxt_s.aw_hold = 1'b0;
      nxt_s.w_hold = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = stl_pkg::RESP_OKAY;
      if (s_ff.aw_addr == stl_pkg::OFF_CTRL) begin
        nxt_s.ctrl = wmerge(s_ff.ctrl, s_ff.w_data, s_ff.w_strb) & stl_pkg::CTRL_MASK;
        mode_chg = nxt_s.ctrl[6:0] != s_ff.ctrl[6:0];
      end else if (s_ff.aw_addr == stl_pkg::OFF_TIME) begin
        nxt_s.tset = wmerge(s_ff.tset, s_ff.w_data, s_ff.w_strb) & stl_pkg::TIME_MASK;
      end else if (s_ff.aw_addr != stl_pkg::OFF_STATUS) begin
        nxt_s.bresp = stl_pkg::RESP_SLVERR;
      end
    end

    // bus read
    if (s_ff.rvalid && axi_req.rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_ff.ar_rdy && axi_req.arvalid) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = stl_pkg::RESP_OKAY;
      nxt_s.rdata = '0;
      if (axi_req.araddr == stl_pkg::OFF_CTRL) begin
        nxt_s.rdata = s_ff.ctrl;
      end else if (axi_req.araddr == stl_pkg::OFF_TIME) begin
        nxt_s.rdata = s_ff.tset;
      end else if (axi_req.araddr == stl_pkg::OFF_STATUS) begin
        nxt_s.rdata = status_w;
      end else begin
        nxt_s.rresp = stl_pkg::RESP_SLVERR;
      end
    end

    // sequencer; states that a branch does not list fall back to idle
    nxt_s.act_prev = act;
    unique case (fn)
      stl_pkg::FN_FOLLOW: begin
        nxt_s.seq = stl_pkg::SQ_IDLE;
      end
      stl_pkg::FN_ON_WAIT, stl_pkg::FN_DLY_LATCH: begin
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if (go) begin
            nxt_s.seq = stl_pkg::SQ_DELAY;
            clr = 1'b1;
          end
          stl_pkg::SQ_DELAY: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end else if (done_d) begin
            nxt_s.seq = (fn == stl_pkg::FN_ON_WAIT) ? stl_pkg::SQ_ON : stl_pkg::SQ_LATCH;
          end
          stl_pkg::SQ_ON: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          stl_pkg::SQ_LATCH: if (aux) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      // on, then hold after loss or inhibit
      stl_pkg::FN_OFF_WAIT, stl_pkg::FN_BOTH_WAIT: begin
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if (go) begin
            nxt_s.seq = (fn == stl_pkg::FN_OFF_WAIT) ? stl_pkg::SQ_ON : stl_pkg::SQ_DELAY;
            clr = 1'b1;
          end
          stl_pkg::SQ_DELAY: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end else if (done_d) begin
            nxt_s.seq = stl_pkg::SQ_ON;
          end
          stl_pkg::SQ_ON: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_HOLD;
            clr = 1'b1;
          end
          stl_pkg::SQ_HOLD: if (go) begin
            nxt_s.seq = stl_pkg::SQ_ON;
          end else if (done_h) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      // single and delayed pulse, edge triggered
      stl_pkg::FN_PULSE, stl_pkg::FN_DLY_PULSE: begin
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if (trig) begin
            nxt_s.seq = (fn == stl_pkg::FN_PULSE) ? stl_pkg::SQ_PULSE : stl_pkg::SQ_DELAY;
            clr = 1'b1;
          end
          stl_pkg::SQ_DELAY: if (aux) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end else if (done_d) begin
            nxt_s.seq = stl_pkg::SQ_PULSE;
            clr = 1'b1;
          end
          stl_pkg::SQ_PULSE: if (done_h) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      stl_pkg::FN_CAPPED: begin
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if (go) begin
            nxt_s.seq = stl_pkg::SQ_ON;
            clr = 1'b1;
          end
          stl_pkg::SQ_ON: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end else if (done_h) begin
            nxt_s.seq = stl_pkg::SQ_LOCK;
          end
          stl_pkg::SQ_LOCK: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      stl_pkg::FN_OSC: begin
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if (go) begin
            nxt_s.seq = stl_pkg::SQ_DELAY;
            clr = 1'b1;
          end
          stl_pkg::SQ_DELAY: if (!go) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end else if (done_d) begin
            nxt_s.seq = stl_pkg::SQ_PULSE;
            clr = 1'b1;
          end
          stl_pkg::SQ_PULSE: if (done_h) begin
            nxt_s.seq = go ? stl_pkg::SQ_DELAY : stl_pkg::SQ_IDLE;
            clr = 1'b1;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      stl_pkg::FN_EDGE_LATCH, stl_pkg::FN_LEVEL_LATCH: begin
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if ((fn == stl_pkg::FN_EDGE_LATCH) ? trig : go) begin
            nxt_s.seq = stl_pkg::SQ_LATCH;
          end
          stl_pkg::SQ_LATCH: if (aux) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      // timer runs only while input present, cleared by auxiliary
      stl_pkg::FN_CAP_LATCH: begin
        run = act;
        unique case (s_ff.seq)
          stl_pkg::SQ_IDLE: if (go) begin
            nxt_s.seq = stl_pkg::SQ_ON;
            clr = 1'b1;
          end
          stl_pkg::SQ_ON: if (aux) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end else if (done_h) begin
            nxt_s.seq = stl_pkg::SQ_LOCK;
          end
          stl_pkg::SQ_LOCK: if (aux) begin
            nxt_s.seq = stl_pkg::SQ_IDLE;
          end
          default: nxt_s.seq = stl_pkg::SQ_IDLE;
        endcase
      end
      default: nxt_s.seq = stl_pkg::SQ_IDLE;
    endcase

    // power-up settle and function change restart the sequence
    if (!s_ff.settled || mode_chg) begin
      nxt_s.seq = stl_pkg::SQ_IDLE;
      clr = 1'b1;
    end
    if (!s_ff.settled && base_tick) begin
      nxt_s.settle = 8'(s_ff.settle + 8'h01);
    end
    nxt_s.settled = nxt_s.settle >= stl_pkg::SETTLE_TICKS;

    if (clr) begin
      nxt_s.cnt = '0;
    end else if (range_tick && run && s_ff.cnt != 8'hff) begin
      nxt_s.cnt = 8'(s_ff.cnt + 8'h01);
    end

    // follow is the gated input itself
    if (fn == stl_pkg::FN_FOLLOW) begin
      nxt_s.out_log = go && !mode_chg && s_ff.settled;
    end else if (fn == stl_pkg::FN_CAP_LATCH && nxt_s.seq == stl_pkg::SQ_ON) begin
      nxt_s.out_log = act;
    end else begin
      nxt_s.out_log = nxt_s.seq inside {stl_pkg::SQ_ON, stl_pkg::SQ_HOLD, stl_pkg::SQ_PULSE,
                                        stl_pkg::SQ_LATCH};
    end
    // output polarity, held low until settled
    nxt_s.out_pin = nxt_s.settled && (nxt_s.out_log ~^ nxt_s.ctrl[stl_pkg::CTRL_IDLE_OPEN_BIT]);

    nxt_s.aw_rdy = !nxt_s.aw_hold && !nxt_s.bvalid;
    nxt_s.w_rdy = !nxt_s.w_hold && !nxt_s.bvalid;
    nxt_s.ar_rdy = !nxt_s.rvalid;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reset: s_ff <= '0;
      s_ff.ctrl <= stl_pkg::CTRL_RST;
      s_ff.tset <= stl_pkg::TIME_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign axi_rsp.awready = s_ff.aw_rdy;
  assign axi_rsp.wready = s_ff.w_rdy;
  assign axi_rsp.bvalid = s_ff.bvalid;
  assign axi_rsp.bresp = s_ff.bresp;
  assign axi_rsp.arready = s_ff.ar_rdy;
  assign axi_rsp.rvalid = s_ff.rvalid;
  assign axi_rsp.rdata = s_ff.rdata;
  assign axi_rsp.rresp = s_ff.rresp;
  assign out_drive = s_ff.out_pin;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  follow_aux_a: assert property (fn == stl_pkg::FN_FOLLOW && aux |=> !s_ff.out_log)
    else $error("follow output on while auxiliary asserted");
  on_wait_time_a: assert property (fn == stl_pkg::FN_ON_WAIT && $rose(s_ff.out_log)
    |-> $past(s_ff.cnt) >= $past(dly))
    else $error("on-wait output before delay elapsed");
  on_wait_aux_a: assert property (fn == stl_pkg::FN_ON_WAIT && aux |=> !s_ff.out_log
    && s_ff.seq == stl_pkg::SQ_IDLE)
    else $error("on-wait auxiliary did not cancel");
  off_wait_hold_a: assert property (fn == stl_pkg::FN_OFF_WAIT && s_ff.seq == stl_pkg::SQ_ON
    && aux && !mode_chg |=> s_ff.out_log && s_ff.seq == stl_pkg::SQ_HOLD && s_ff.cnt == 8'h00)
    else $error("off-wait hold not entered on inhibit");
  pulse_block_a: assert property (fn == stl_pkg::FN_PULSE && s_ff.seq == stl_pkg::SQ_IDLE
    && aux |=> !s_ff.out_log)
    else $error("single pulse triggered while inhibited");
  dly_abort_a: assert property (fn == stl_pkg::FN_DLY_PULSE && s_ff.seq == stl_pkg::SQ_DELAY
    && aux |=> s_ff.seq == stl_pkg::SQ_IDLE ##1 !s_ff.out_log)
    else $error("delayed pulse not aborted");
  capped_off_a: assert property (fn == stl_pkg::FN_CAPPED && s_ff.seq == stl_pkg::SQ_ON
    && done_h |=> !s_ff.out_log)
    else $error("capped output beyond hold time");
  osc_finish_a: assert property (fn == stl_pkg::FN_OSC && s_ff.seq == stl_pkg::SQ_PULSE
    && !done_h && !mode_chg |=> s_ff.out_log)
    else $error("oscillate hold cut short");
  edge_onset_a: assert property (fn == stl_pkg::FN_EDGE_LATCH && $rose(s_ff.out_log)
    |-> $past(act) && !$past(s_ff.act_prev))
    else $error("edge latch set without onset");
  settle_off_a: assert property (!s_ff.settled |-> !out_drive)
    else $error("output driven before settle");

endmodule

// *** tb/stl_partner.sv ***
// sensor receiver and auxiliary contact model
// assumes bench commands light and inhibit on clk
`timescale 1ns/10ps
module stl_partner (
  input wire logic light,
  input wire logic inhibit,
  output logic sense_in,
  output logic aux_n
);
  assign sense_in = light;
  // open collector contact, pulls low while closed
  assign aux_n = ~inhibit;
endmodule

// *** tb/stl_tb_top.sv ***
// self-checking bench of stl_core with a sensor model
// assumes BASE_CYC of 10, so a low-range tick is 10 cycles
`timescale 1ns/10ps
module sensor_timing_logic_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic light = 1'b0;
  logic inhibit = 1'b0;
  logic sense_in;
  logic aux_n;
  logic out_drive;
  stl_pkg::stl_axi_req_s req = '0;
  stl_pkg::stl_axi_rsp_s rsp;
  logic [31:0] rd;
  logic [1:0] rs;
  int fail_count = 0;
  int total_checks = 0;
  stl_partner u_part (.light(light), .inhibit(inhibit), .sense_in(sense_in), .aux_n(aux_n));
  stl_core #(.BASE_CYC(10)) u_dut (.clk(clk), .sys_rst(sys_rst), .sense_in(sense_in), .aux_n(aux_n),
    .axi_req(req), .axi_rsp(rsp), .out_drive(out_drive));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pin(input logic l, input logic i, input int n);
    @(posedge clk);
    light <= l;
    inhibit <= i;
    cyc(n);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(negedge clk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (!b);
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(negedge clk);
      ar = req.arvalid & rsp.arready;
      r = rsp.rvalid;
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge clk);
      if (ar) req.arvalid <= 1'b0;
    end while (!r);
    req.rready <= 1'b0;
  endtask
  task automatic t_regs;
    axr(stl_pkg::OFF_CTRL);
    chk("ctrl reset", stl_pkg::CTRL_RST, rd);
    axr(stl_pkg::OFF_TIME);
    chk("time reset", stl_pkg::TIME_RST, rd);
    axr(8'h0c);
    chk("unmapped read", {30'h0, stl_pkg::RESP_SLVERR}, {30'h0, rs});
    axw(8'h0c, 32'h1);
    chk("unmapped write", {30'h0, stl_pkg::RESP_SLVERR}, {30'h0, rs});
    axw(stl_pkg::OFF_TIME, 32'h3214);
    chk("write okay", {30'h0, stl_pkg::RESP_OKAY}, {30'h0, rs});
    axr(stl_pkg::OFF_TIME);
    chk("time write", 32'h3214, rd);
    chk("read okay", {30'h0, stl_pkg::RESP_OKAY}, {30'h0, rs});
    axw(stl_pkg::OFF_TIME, 32'h0a0a);
  endtask
  task automatic t_follow;
    chk("follow on", 32'h1, out_drive);
    pin(1'b1, 1'b1, 5);
    chk("follow aux", 32'h0, out_drive);
    pin(1'b1, 1'b0, 5);
    chk("follow back", 32'h1, out_drive);
    pin(1'b0, 1'b0, 5);
    chk("follow off", 32'h0, out_drive);
  endtask
  // quantised ticks: checks sit well clear of the 90..105 cycle window
  task automatic t_onwait;
    axw(stl_pkg::OFF_CTRL, 32'h4d3);
    pin(1'b1, 1'b0, 60);
    pin(1'b0, 1'b0, 10);
    pin(1'b1, 1'b0, 80);
    chk("delay restart", 32'h0, out_drive);
    cyc(40);
    chk("delay done", 32'h1, out_drive);
    pin(1'b1, 1'b1, 5);
    chk("delay aux", 32'h0, out_drive);
    pin(1'b1, 1'b0, 50);
    chk("delay rearm", 32'h0, out_drive);
    pin(1'b0, 1'b0, 5);
  endtask
  task automatic t_sense;
    axw(stl_pkg::OFF_CTRL, 32'h457);
    cyc(5);
    chk("idle closed", 32'h1, out_drive);
    axw(stl_pkg::OFF_CTRL, 32'h0d7);
    cyc(5);
    chk("shadow dark", 32'h1, out_drive);
    pin(1'b1, 1'b0, 5);
    chk("shadow light", 32'h0, out_drive);
    pin(1'b0, 1'b0, 5);
  endtask
  task automatic t_pulse;
    axw(stl_pkg::OFF_CTRL, 32'h4d4);
    pin(1'b1, 1'b0, 5);
    chk("pulse start", 32'h1, out_drive);
    pin(1'b0, 1'b1, 45);
    chk("pulse runs", 32'h1, out_drive);
    cyc(80);
    chk("pulse end", 32'h0, out_drive);
    pin(1'b1, 1'b1, 5);
    chk("pulse blocked", 32'h0, out_drive);
    pin(1'b0, 1'b0, 5);
  endtask
  task automatic t_offwait;
    axw(stl_pkg::OFF_CTRL, 32'h4d5);
    pin(1'b1, 1'b0, 5);
    chk("offwait on", 32'h1, out_drive);
    pin(1'b0, 1'b1, 50);
    chk("offwait hold", 32'h1, out_drive);
    cyc(80);
    chk("offwait end", 32'h0, out_drive);
    pin(1'b1, 1'b1, 5);
    chk("offwait block", 32'h0, out_drive);
    pin(1'b0, 1'b0, 5);
  endtask
  task automatic t_latch;
    axw(stl_pkg::OFF_CTRL, 32'h4f6);
    pin(1'b1, 1'b0, 5);
    pin(1'b0, 1'b0, 5);
    chk("edge latched", 32'h1, out_drive);
    pin(1'b1, 1'b0, 5);
    pin(1'b1, 1'b1, 5);
    pin(1'b1, 1'b0, 5);
    chk("edge no relatch", 32'h0, out_drive);
    axw(stl_pkg::OFF_CTRL, 32'h4f7);
    cyc(5);
    chk("level latched", 32'h1, out_drive);
    pin(1'b1, 1'b1, 5);
    chk("level cleared", 32'h0, out_drive);
    pin(1'b1, 1'b0, 5);
    chk("level relatch", 32'h1, out_drive);
    pin(1'b0, 1'b0, 5);
    chk("level held", 32'h1, out_drive);
  endtask
  task automatic t_capped;
    axw(stl_pkg::OFF_CTRL, 32'h4c3);
    pin(1'b1, 1'b0, 60);
    chk("capped on", 32'h1, out_drive);
    cyc(60);
    chk("capped off", 32'h0, out_drive);
    pin(1'b1, 1'b1, 5);
    pin(1'b1, 1'b0, 5);
    chk("capped restart", 32'h1, out_drive);
    pin(1'b0, 1'b0, 5);
    chk("capped follow", 32'h0, out_drive);
  endtask
  task automatic t_osc;
    axw(stl_pkg::OFF_CTRL, 32'h4d9);
    pin(1'b1, 1'b0, 80);
    chk("osc delay", 32'h0, out_drive);
    cyc(40);
    chk("osc pulse", 32'h1, out_drive);
    pin(1'b0, 1'b0, 50);
    chk("osc finish", 32'h1, out_drive);
    cyc(60);
    chk("osc stop", 32'h0, out_drive);
  endtask
  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    pin(1'b1, 1'b0, 50);
    chk("settle off", 32'h0, out_drive);
    t_regs;
    cyc(250);
    t_follow;
    t_onwait;
    t_sense;
    t_pulse;
    t_offwait;
    t_latch;
    t_capped;
    t_osc;
    give_verdict;
  end
  initial begin
    cyc(20000);
    fail_count++;
    give_verdict;
  end
endmodule
